//--- verilog/bisg_gate.sv
`timescale 1ns/1ps
`include "bisg_defs.svh"
// Operation
// - two inputs evaluated independently
// - per-channel choice of edge and return reactions
// - no reaction before start-up delay expires
// - edges during delay dropped, never queued
// - one shared delay for all channels
// - rate limit blocks input telegrams 17 s
// - return reaction skipped if delay ends inside
// - rate limit enable is one global bit
// - cyclic telegrams held by the limit too
// - disabled channel yields nothing at all
// - first cyclic send not before start-up delay expires
module bisg_gate #(
  parameter int unsigned RATE_CYC = `BISG_RATE_CYC,
  parameter int unsigned MS_CYC = `BISG_MS_CYC
) (
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // bus voltage return event, same clock
  input wire logic bus_return_in,
  // contact pins
  input wire logic [1:0] contact_in,
  // cyclic send request from the generators
  input wire logic [1:0] cyclic_req_in,
  // reaction events to the generators
  output bisg_pkg::bisg_event_s [1:0] event_out,
  output logic [1:0] cyclic_ok_out,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // software registers
  logic [31:0] ctrl;
  logic [31:0] cfg;
  logic [31:0] delay_ms;
  // captured write halves
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // three-stage pin synchronisers
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] level;
  // startup sequencing
  bisg_pkg::bisg_state_e state;
  logic [31:0] ms_cnt;
  logic [31:0] delay_cnt;
  logic [31:0] rate_cnt;
  logic rate_run;
  logic [31:0] rd_value;
  logic rd_ok;

  // write channel capture in either order
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (clk_en_in) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_held <= 1'b0;
      end
    end
  end

  // ready flags are registered, high while a half is free
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (clk_en_in) begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // register writes and response once both halves held
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl <= `BISG_CTRL_RST;
      cfg <= `BISG_CFG_RST;
      delay_ms <= `BISG_DELAY_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BISG_RESP_OKAY;
    end else if (clk_en_in) begin
      if (s_axi_bvalid) begin
        if (s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end else if (aw_held && w_held) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `BISG_RESP_OKAY;
        // one global limit enable and one shared delay
        // global rate enable
        if (aw_addr[7:0] == 8'(`BISG_REG_CTRL)) begin
          for (int b = 0; b < 4; b++) if (w_strb[b]) ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
        end else if (aw_addr[7:0] == 8'(`BISG_REG_CFG)) begin
          for (int b = 0; b < 4; b++) if (w_strb[b]) cfg[b*8 +: 8] <= w_data[b*8 +: 8];
        end else if (aw_addr[7:0] == 8'(`BISG_REG_DELAY)) begin
          for (int b = 0; b < 4; b++) if (w_strb[b]) delay_ms[b*8 +: 8] <= w_data[b*8 +: 8];
        end else if (aw_addr[7:0] == 8'(`BISG_REG_STATUS)) begin
          s_axi_bresp <= `BISG_RESP_OKAY;
        end else begin
          // unmapped
          s_axi_bresp <= `BISG_RESP_SLVERR;
        end
      end
    end
  end

  // read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:0] == 8'(`BISG_REG_CTRL)) begin
      rd_value = ctrl;
    end else if (s_axi_araddr[7:0] == 8'(`BISG_REG_CFG)) begin
      rd_value = cfg;
    end else if (s_axi_araddr[7:0] == 8'(`BISG_REG_DELAY)) begin
      rd_value = delay_ms;
    end else if (s_axi_araddr[7:0] == 8'(`BISG_REG_STATUS)) begin
      rd_value[`BISG_STAT_DELAY_RUN] = (state == bisg_pkg::BISG_ST_DELAY);
      rd_value[`BISG_STAT_RATE_RUN] = rate_run;
      rd_value[`BISG_STAT_LEVEL0] = level[0];
      rd_value[`BISG_STAT_LEVEL1] = level[1];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read channel, answer one cycle after address taken
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BISG_RESP_OKAY;
    end else if (clk_en_in) begin
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
        s_axi_arready <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_ok ? `BISG_RESP_OKAY : `BISG_RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // pin synchroniser; level moves when stages two and three agree
  // independent channel sampling
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      sync3 <= 2'h0;
      level <= 2'h0;
    end else if (clk_en_in) begin
      sync1 <= contact_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int c = 0; c < 2; c++) if (sync2[c] == sync3[c]) level[c] <= sync3[c];
    end
  end

  // start-up delay after reset or bus return
  // hold off reactions
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= bisg_pkg::BISG_ST_DELAY;
      ms_cnt <= 32'h0000_0000;
      delay_cnt <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (bus_return_in) begin
        state <= bisg_pkg::BISG_ST_DELAY;
        ms_cnt <= 32'h0000_0000;
        delay_cnt <= 32'h0000_0000;
      end else begin
        case (state)
          bisg_pkg::BISG_ST_DELAY: begin
            if (delay_cnt >= delay_ms) begin
              state <= bisg_pkg::BISG_ST_RETURN;
            end else if (ms_cnt == MS_CYC - 1) begin
              ms_cnt <= 32'h0000_0000;
              delay_cnt <= delay_cnt + 32'h0000_0001;
            end else begin
              ms_cnt <= ms_cnt + 32'h0000_0001;
            end
          end
          bisg_pkg::BISG_ST_RETURN: state <= bisg_pkg::BISG_ST_RUN;
          default: state <= bisg_pkg::BISG_ST_RUN;
        endcase
      end
    end
  end

  // 17 s window after bus return
  // rate window timer
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rate_cnt <= 32'h0000_0000;
      rate_run <= 1'b0;
    end else if (clk_en_in) begin
      if (bus_return_in) begin
        rate_cnt <= 32'h0000_0000;
        rate_run <= 1'b1;
      end else if (rate_run) begin
        if (rate_cnt == RATE_CYC - 1) begin
          rate_run <= 1'b0;
        end else begin
          rate_cnt <= rate_cnt + 32'h0000_0001;
        end
      end
    end
  end

  // channel enables, limit window in force, channels past the shared delay and outside the window
  logic [1:0] chan_on;
  logic quiet;
  logic run;
  assign chan_on = {cfg[`BISG_CFG_W + `BISG_CFG_FUNC_EN], cfg[`BISG_CFG_FUNC_EN]};
  assign quiet = ctrl[`BISG_CTRL_RATE_EN] && rate_run;
  assign run = (state == bisg_pkg::BISG_ST_RUN) && !quiet;

  // reaction events; limit also gates the cyclic send grant
  // input and cyclic telegrams gated
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      event_out <= '0;
      cyclic_ok_out <= 2'h0;
    end else if (clk_en_in) begin
      for (int c = 0; c < 2; c++) begin
        event_out[c].rise <= chan_on[c] && run && cfg[c*`BISG_CFG_W + `BISG_CFG_RISE]
                             && (sync2[c] == sync3[c]) && sync3[c] && !level[c];
        event_out[c].fall <= chan_on[c] && run && cfg[c*`BISG_CFG_W + `BISG_CFG_FALL]
                             && (sync2[c] == sync3[c]) && !sync3[c] && level[c];
        event_out[c].on_return <= chan_on[c] && !quiet && (state == bisg_pkg::BISG_ST_RETURN)
                                  && cfg[c*`BISG_CFG_W + `BISG_CFG_RETURN];
        cyclic_ok_out[c] <= chan_on[c] && run && cyclic_req_in[c];
      end
    end
  end
endmodule // bisg_gate

//--- verilog/bisg_defs.svh
`ifndef BISG_DEFS_SVH
`define BISG_DEFS_SVH
// register byte offsets
`define BISG_REG_CTRL 32'h0000_0000
`define BISG_REG_CFG 32'h0000_0004
`define BISG_REG_DELAY 32'h0000_0008
`define BISG_REG_STATUS 32'h0000_000C
// control field positions
`define BISG_CTRL_RATE_EN 0
// per-channel config fields, channel n at bits n*8
`define BISG_CFG_W 8
`define BISG_CFG_FUNC_EN 0
`define BISG_CFG_RISE 1
`define BISG_CFG_FALL 2
`define BISG_CFG_RETURN 3
// status field positions
`define BISG_STAT_DELAY_RUN 0
`define BISG_STAT_RATE_RUN 1
`define BISG_STAT_LEVEL0 2
`define BISG_STAT_LEVEL1 3
// reset values
`define BISG_CTRL_RST 32'h0000_0000
`define BISG_CFG_RST 32'h0000_0000
`define BISG_DELAY_RST 32'h0000_0000
// timing: clock in MHz, rate window in seconds, delay unit in ms
`define BISG_CLK_MHZ 50
`define BISG_RATE_S 17
`define BISG_RATE_CYC (`BISG_RATE_S * 1000000 * `BISG_CLK_MHZ)
`define BISG_MS_CYC (1000 * `BISG_CLK_MHZ)
// axi response codes
`define BISG_RESP_OKAY 2'h0
`define BISG_RESP_SLVERR 2'h2
`endif

//--- verilog/bisg_pkg.sv
package bisg_pkg;
  // one event per channel towards the telegram generators
  typedef struct packed {
    logic rise;
    logic fall;
    logic on_return;
  } bisg_event_s;
  // startup sequencing states
  typedef enum logic [1:0] {
    BISG_ST_DELAY,
    BISG_ST_RETURN,
    BISG_ST_RUN
  } bisg_state_e;
endpackage

//--- bench/bisg_gate_sva.sv
`timescale 1ns/1ps
module bisg_gate_sva (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // clock enable; nothing moves while it is low
  input wire logic clk_en_in,
  // gate side
  input wire logic [1:0] cyclic_req_in,
  input wire bisg_pkg::bisg_event_s [1:0] event_out,
  input wire logic [1:0] cyclic_ok_out,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in || !clk_en_in);
  property p_rise; event_out[0].rise |=> !event_out[0].rise; endproperty
  a_rise: assert property (p_rise) else $error("rise pulse too long");
  property p_excl; event_out[0].rise |-> !event_out[0].fall; endproperty
  a_excl: assert property (p_excl) else $error("rise and fall together");
  property p_ret; event_out[0].on_return |=> !event_out[0].on_return; endproperty
  a_ret: assert property (p_ret) else $error("return reaction repeated");
  property p_cyc; (cyclic_ok_out & ~$past(cyclic_req_in)) == 2'h0; endproperty
  a_cyc: assert property (p_cyc) else $error("cyclic send without request");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while busy");
  property p_awblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_awblk: assert property (p_awblk) else $error("write taken while busy");
  property p_rend; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rend: assert property (p_rend) else $error("read data repeated");
endmodule // bisg_gate_sva
bind bisg_gate bisg_gate_sva u_sva (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .clk_en_in(clk_en_in),
  .cyclic_req_in(cyclic_req_in), .event_out(event_out), .cyclic_ok_out(cyclic_ok_out),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- bench/bisg_contact_model.sv
`timescale 1ns/1ps
module bisg_contact_model (
  // button state wanted by the bench
  input wire logic [1:0] press_in,
  // contact pins, off the clock edge
  output logic [1:0] contact_out
);
  initial contact_out = 2'h0;
  // contacts follow the button a little late
  always @(press_in) contact_out <= #7 press_in;
endmodule // bisg_contact_model

//--- bench/testbench.sv
`timescale 1ns/1ps
`define CHK(a,b) begin automatic logic [33:0] v = (b); checks_done++; if ((a) !== v) begin \
  error_cnt++; $display("Error %0t got %0h exp %0h", $time, (a), v); end end
module testbench;
  logic sys_clk_in = 1'b0, rst_in = 1'b1, bus_return_in = 1'b0, clk_en = 1'b1;
  logic [1:0] press = '0, contact_in, cyclic_req_in = '0, cyclic_ok_out, bresp, rresp;
  bisg_pkg::bisg_event_s [1:0] event_out;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [33:0] rq[$];
  logic [5:0] eq[$];
  int error_cnt = 0, checks_done = 0;
  initial forever #10 sys_clk_in = ~sys_clk_in;
  bisg_gate #(.RATE_CYC(200), .MS_CYC(4)) DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .clk_en_in(clk_en), .bus_return_in(bus_return_in), .contact_in(contact_in),
    .cyclic_req_in(cyclic_req_in), .event_out(event_out), .cyclic_ok_out(cyclic_ok_out),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  bisg_contact_model u_cm (.press_in(press), .contact_out(contact_in));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // bus write, response code noted for the monitor
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, 32'h0});
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1; tick(1); bready <= 1'b0;
  endtask
  // bus read, expected response and data noted
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    rq.push_back(e); araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1; tick(1); rready <= 1'b0;
  endtask
  task automatic bret;
    bus_return_in <= 1'b1; tick(1); bus_return_in <= 1'b0;
  endtask
  // move buttons, note the event expected if any
  task automatic push(input logic [1:0] p, input logic [5:0] e);
    if (e != 6'h0) eq.push_back(e);
    press <= p; tick(12);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // monitor: every answer and event against the oldest note
  always @(posedge sys_clk_in) begin
    if (bvalid && bready) `CHK({bresp, 32'h0}, rq.pop_front())
    if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front())
    if (event_out !== 6'h0) `CHK(event_out, eq.size() ? eq.pop_front() : 6'h0)
  end
  initial begin
    tick(4000); error_cnt++; final_report;
  end
  initial begin
    void'($urandom(84987));
    tick(16); rst_in <= 1'b0; tick(2);
    // reset values, unmapped place, read-only status
    rd(32'h0, 34'h0); rd(32'h4, 34'h0); rd(32'h8, 34'h0); rd(32'hC, 34'h0);
    rd(32'h10, {2'h2, 32'h0}); wr(32'h10, 32'h1, 2'h2); wr(32'hC, 32'h1, 2'h0);
    // byte lanes: only lane one of the delay word may change
    wstrb <= 4'h2;
    wr(32'h8, 32'h0000_3C77, 2'h0);
    wstrb <= 4'hF;
    rd(32'h8, {2'h0, 32'h0000_3C00});
    $display("test registers done");
    // edges inside the shared delay are dropped
    wr(32'h8, 32'hA, 2'h0); wr(32'h4, 32'h0000_030F, 2'h0);
    eq.push_back(6'h01); bret;
    push(2'h1, 6'h0); push(2'h0, 6'h0); tick(40);
    push(2'h1, 6'h04); push(2'h3, 6'h20); push(2'h2, 6'h02); push(2'h0, 6'h0);
    wr(32'h4, 32'h0000_0E0F, 2'h0);
    push(2'h2, 6'h0); push(2'h0, 6'h0);
    // frozen enable: pin change ignored until it returns, then the edge shows
    clk_en <= 1'b0;
    push(2'h1, 6'h0);
    clk_en <= 1'b1;
    push(2'h1, 6'h04);
    push(2'h0, 6'h02);
    $display("test delay done");
    // rate window: return skipped when delay ends inside it
    wr(32'h0, 32'h1, 2'h0);
    for (int i = 0; i < 2; i++) begin
      wr(32'h8, 32'(i * 60), 2'h0);
      if (i == 1) eq.push_back(6'h01);
      bret;
      cyclic_req_in <= 2'($urandom); tick(100);
      `CHK(cyclic_ok_out, 2'h0)
      push(2'h1, 6'h0); push(2'h0, 6'h0);
      tick(130); cyclic_req_in <= 2'h3; tick(2);
      `CHK(cyclic_ok_out, 2'h1)
      push(2'h1, 6'h04); push(2'h0, 6'h02);
      cyclic_req_in <= 2'h0;
    end
    $display("test rate limit done");
    `CHK(eq.size(), 0)
    final_report;
  end
endmodule // testbench
